/* File: mwpc_pkg.sv */
/*
  Shared constants and types for the MFM write precompensation and clocking block:
  timing counts, bit-cell layout, register map, precompensation table and state types.
  Assumes a single reference clock at CLK_FREQ_HZ and a synchronous active-high reset.
*/
package mwpc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ = 25_000_000; // Reference clock rate
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ; // Period in ns
  localparam int unsigned PC_DELAY_NS = 12; // One precompensation delay interval
  // Longest-time style rounding down, but never below one cycle
  localparam int unsigned PC_DELAY_CYC =
    ((PC_DELAY_NS / CLK_PERIOD_NS) > 0) ? (PC_DELAY_NS / CLK_PERIOD_NS) : 1;
  localparam logic [2:0] PC_DELAY = 3'(PC_DELAY_CYC); // Shift in cycles

  // ==========================================================================
  // Bit cell layout (eight reference cycles per cell)
  // ==========================================================================
  localparam logic [2:0] CELL_LAST = 3'h7; // Last phase of a bit cell
  localparam logic [2:0] CLK_POS = 3'h2; // Shift_none clock pulse phase
  localparam logic [2:0] DAT_POS = 3'h6; // Shift_none data pulse phase
  localparam logic [2:0] CLK_LOCK = 3'h3; // Read phase forced on a clock pulse
  localparam logic [2:0] BYTE_LAST = 3'h7; // Last bit index of a byte

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] REG_CTRL = 4'h0; // Control register offset
  localparam logic [3:0] REG_STATUS = 4'h4; // Status register offset
  localparam int unsigned CTRL_PC_EN_BIT = 0; // Precompensation enable
  localparam int unsigned CTRL_WR_GATE_BIT = 1; // Write gate
  localparam logic [1:0] CTRL_RST = 2'h0; // Control reset value
  localparam int unsigned ST_BUSY_BIT = 0; // Serializer busy
  localparam int unsigned ST_EMPTY_BIT = 1; // FIFO empty
  localparam int unsigned ST_FULL_BIT = 2; // FIFO full
  localparam int unsigned ST_OUTC_LSB = 4; // Current shift outcome, 2 bits
  localparam int unsigned ST_LEVEL_LSB = 8; // FIFO level, 6 bits

  // ==========================================================================
  // Buffer geometry
  // ==========================================================================
  localparam int unsigned FIFO_W = 8; // Byte wide
  localparam int unsigned FIFO_DEPTH = 32; // Words

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MWPC_SHIFT_NONE = 2'h0,
    MWPC_SHIFT_EARLY = 2'h1,
    MWPC_SHIFT_LATE = 2'h2
  } mwpc_shift_e;

  // Indexed by {previous, present}: 00 none, 01 early, 10 none, 11 late
  localparam logic [7:0] PC_TABLE = 8'h84;

  typedef enum logic [1:0] {
    MWPC_WR_IDLE = 2'h0,
    MWPC_WR_SHIFT = 2'h1
  } mwpc_wr_e;

  typedef struct packed {
    logic wclk; // Halved reference clock
    mwpc_wr_e wr; // Serializer state
    logic [7:0] sr; // Byte being written, MSB first
    logic [2:0] bit_idx; // Bit within byte
    logic [2:0] phase; // Phase within write cell
    logic prev; // Previously written data bit
    mwpc_shift_e outcome; // Registered shift outcome
    logic enc; // Encoded write pulse
    logic [1:0] ctrl; // Control register
    logic [31:0] rdata; // Bus read data
    logic rd_s1; // Read pin sync stage 1
    logic rd_s2; // Read pin sync stage 2
    logic rd_s3; // Read pin sync stage 3
    logic rd_lvl; // Accepted read pin level
    logic [2:0] rd_phase; // Recovered cell phase
    logic rclk; // Recovered read clock
    logic rd_seen; // Data pulse seen this cell
    logic rd_bit; // Separated data bit
    logic rd_stb; // Data bit strobe
  } mwpc_state_s;

  localparam mwpc_state_s STATE_RST = '0; // All-zero reset state

endpackage : mwpc_pkg

/* File: mwpc_top.sv */
/*
  MFM write precompensation and clocking: write clock divider, byte FIFO,
  MFM serializer with three-way precompensation, digital read clock recovery,
  and a small register port.
  Assumes one reference clock, a synchronous reset, and a register master that
  uses one-cycle strobes and takes read data in the cycle after the read strobe.
*/
// Operation
// - Write clock is reference divided by two
// - Halved clock also drives processor clock out
// - Compare previous and present bit, one outcome
// - Early or late pulses offset one delay
// - Enable low forces no-shift for every pulse
// - Outcome selects pulse timing, sent differentially
// - Clock pulse only when both bits zero
// - One is data pulse, zero no pulse
// - Synthesize clock timing, resync on clock pulses
// - Read clock half rate, phase locked

// ============================================================================
// Byte FIFO
// ============================================================================
module mwpc_fifo #(
  parameter int unsigned W = 8, // Word width
  parameter int unsigned DEPTH = 32 // Word count
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic in_valid_i, // Writer has a word
  input wire logic [W-1:0] in_data_i, // Word to store
  output logic in_ready_o, // Room for a word
  output logic out_valid_o, // Word available
  output logic [W-1:0] out_data_o, // Oldest word
  input wire logic out_ready_i, // Reader takes word
  output logic [$clog2(DEPTH):0] level_o // Words held
);
  localparam int unsigned AW = $clog2(DEPTH); // Pointer width
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH); // Count when full

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Storage flops
    logic [AW-1:0] wp; // Write index
    logic [AW-1:0] rp; // Read index
    logic [AW:0] cnt; // Occupancy
  } mwpc_fifo_s;

  mwpc_fifo_s st_ff; // Registered state
  mwpc_fifo_s nxt_st; // Next state
  logic push; // Word accepted
  logic pop; // Word released

  assign in_ready_o = (st_ff.cnt != FULL_CNT);
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign level_o = st_ff.cnt;

  // Next state: push and pop may happen in one cycle
  always_comb begin
    nxt_st = st_ff;
    push = in_valid_i && in_ready_o;
    pop = out_ready_i && out_valid_o;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : mwpc_fifo

// ============================================================================
// Top
// ============================================================================
module mwpc_top (
  input wire logic REF_CLK_I, // Reference clock
  input wire logic RST_I, // Synchronous reset, active high
  input wire logic [3:0] ADDR_I, // Register byte address
  input wire logic [31:0] WDATA_I, // Register write data
  input wire logic WR_I, // Register write strobe
  input wire logic RD_I, // Register read strobe
  output logic [31:0] RDATA_O, // Read data, cycle after strobe
  input wire logic [7:0] WR_DATA_I, // Byte to write
  input wire logic WR_VALID_I, // Byte offered
  output logic WR_READY_O, // FIFO has room
  output logic WCLK_O, // Write clock
  output logic CPU_CLK_O, // Processor clock
  output logic PRECOMP_ENABLE_LINE_O, // Precompensation enable level
  output logic SHIFT_EARLY_O, // Early outcome
  output logic SHIFT_NONE_O, // No-shift outcome
  output logic SHIFT_LATE_O, // Late outcome
  output logic ENCODED_WRITE_OUT_O, // Encoded write pulse
  output logic ENC_WR_P_O, // Differential true side
  output logic ENC_WR_N_O, // Differential complement side
  input wire logic RD_MFM_I, // Read pulses from drive
  output logic RCLK_O, // Recovered read clock
  output logic RD_BIT_O, // Separated data bit
  output logic RD_BIT_STB_O // Data bit strobe, one cycle
);
  mwpc_pkg::mwpc_state_s st_ff; // Registered state
  mwpc_pkg::mwpc_state_s nxt_st; // Next state
  logic fifo_valid; // Byte waiting
  logic fifo_ready; // Serializer takes byte
  logic [7:0] fifo_data; // Byte at head
  logic [5:0] fifo_level; // FIFO occupancy
  logic fifo_full; // Writer stalled
  logic cur; // Present data bit
  logic pulse_need; // Cell carries a pulse
  logic [2:0] base_pos; // Shift_none pulse phase
  logic [2:0] pulse_pos; // Shifted pulse phase
  mwpc_pkg::mwpc_shift_e shift_c; // Outcome for this cell
  logic cell_end; // Last phase of write cell
  logic byte_end; // Last cell of byte
  logic rd_evt; // Rising read pulse accepted
  logic rd_clk_win; // Read phase in clock half

  // ==========================================================================
  // Buffer
  // ==========================================================================
  // Writer back-pressure reaches WR_READY_O; drained only while writing
  mwpc_fifo #(
    .W(mwpc_pkg::FIFO_W),
    .DEPTH(mwpc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .in_valid_i(WR_VALID_I),
    .in_data_i(WR_DATA_I),
    .in_ready_o(WR_READY_O),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_ready),
    .level_o(fifo_level)
  );
  assign fifo_full = !WR_READY_O;

  // ==========================================================================
  // Write path decode
  // ==========================================================================
  // Per-cell pulse placement from the present and previous bits
  always_comb begin
    cur = st_ff.sr[7];
    cell_end = (st_ff.phase == mwpc_pkg::CELL_LAST);
    byte_end = cell_end && (st_ff.bit_idx == mwpc_pkg::BYTE_LAST);
    pulse_need = cur || !st_ff.prev;
    base_pos = cur ? mwpc_pkg::DAT_POS : mwpc_pkg::CLK_POS;
    // Table lookup only while enabled; otherwise no shift at all
    if (st_ff.ctrl[mwpc_pkg::CTRL_PC_EN_BIT]) begin
      shift_c = mwpc_pkg::mwpc_shift_e'(mwpc_pkg::PC_TABLE[{st_ff.prev, cur}*2 +: 2]);
    end else begin
      shift_c = mwpc_pkg::MWPC_SHIFT_NONE;
    end
    case (shift_c)
      mwpc_pkg::MWPC_SHIFT_EARLY: pulse_pos = base_pos - mwpc_pkg::PC_DELAY;
      mwpc_pkg::MWPC_SHIFT_LATE: pulse_pos = base_pos + mwpc_pkg::PC_DELAY;
      default: pulse_pos = base_pos;
    endcase
    // Take a new byte when idle, or back to back at the end of a byte
    case (st_ff.wr)
      mwpc_pkg::MWPC_WR_IDLE: fifo_ready = st_ff.ctrl[mwpc_pkg::CTRL_WR_GATE_BIT];
      mwpc_pkg::MWPC_WR_SHIFT: fifo_ready = byte_end && st_ff.ctrl[mwpc_pkg::CTRL_WR_GATE_BIT];
      default: fifo_ready = 1'b0;
    endcase
  end

  // ==========================================================================
  // Read path decode
  // ==========================================================================
  // Only the second and third sync stages are looked at
  assign rd_evt = (st_ff.rd_s2 == st_ff.rd_s3) && st_ff.rd_s2 && !st_ff.rd_lvl;
  assign rd_clk_win = !st_ff.rd_phase[2];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_st = st_ff;
    // Divide-by-two write clock
    nxt_st.wclk = !st_ff.wclk;

    // Serializer
    case (st_ff.wr)
      mwpc_pkg::MWPC_WR_IDLE: begin
        if (fifo_valid && fifo_ready) begin
          nxt_st.sr = fifo_data;
          nxt_st.bit_idx = 3'h0;
          nxt_st.phase = 3'h0;
          nxt_st.wr = mwpc_pkg::MWPC_WR_SHIFT;
        end
      end
      mwpc_pkg::MWPC_WR_SHIFT: begin
        nxt_st.phase = st_ff.phase + 3'h1;
        if (cell_end) begin
          nxt_st.prev = cur;
          nxt_st.sr = {st_ff.sr[6:0], 1'b0};
          nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
        end
        if (byte_end) begin
          // Gate drop lets the current byte finish before idling
          if (fifo_valid && fifo_ready) begin
            nxt_st.sr = fifo_data;
            nxt_st.bit_idx = 3'h0;
          end else begin
            nxt_st.wr = mwpc_pkg::MWPC_WR_IDLE;
          end
        end
      end
      default: nxt_st.wr = mwpc_pkg::MWPC_WR_IDLE;
    endcase

    // Outcome lines and the pulse itself
    if (st_ff.wr == mwpc_pkg::MWPC_WR_SHIFT) begin
      nxt_st.outcome = shift_c;
      nxt_st.enc = pulse_need && (st_ff.phase == pulse_pos);
    end else begin
      nxt_st.outcome = mwpc_pkg::MWPC_SHIFT_NONE;
      nxt_st.enc = 1'b0;
    end

    // Register port
    if (WR_I && (ADDR_I == mwpc_pkg::REG_CTRL)) begin
      nxt_st.ctrl = WDATA_I[1:0];
    end
    nxt_st.rdata = 32'h0;
    if (RD_I) begin
      case (ADDR_I)
        mwpc_pkg::REG_CTRL: nxt_st.rdata = {30'h0, st_ff.ctrl};
        mwpc_pkg::REG_STATUS: begin
          nxt_st.rdata[mwpc_pkg::ST_BUSY_BIT] = (st_ff.wr == mwpc_pkg::MWPC_WR_SHIFT);
          nxt_st.rdata[mwpc_pkg::ST_EMPTY_BIT] = !fifo_valid;
          nxt_st.rdata[mwpc_pkg::ST_FULL_BIT] = fifo_full;
          nxt_st.rdata[mwpc_pkg::ST_OUTC_LSB +: 2] = st_ff.outcome;
          nxt_st.rdata[mwpc_pkg::ST_LEVEL_LSB +: 6] = fifo_level;
        end
        default: nxt_st.rdata = 32'h0; // Unmapped reads zero
      endcase
    end

    // Read pin synchroniser and level filter
    nxt_st.rd_s1 = RD_MFM_I;
    nxt_st.rd_s2 = st_ff.rd_s1;
    nxt_st.rd_s3 = st_ff.rd_s2;
    if (st_ff.rd_s2 == st_ff.rd_s3) begin
      nxt_st.rd_lvl = st_ff.rd_s2;
    end

    // Recovered cell timing: free-runs through missing clock pulses
    nxt_st.rd_phase = st_ff.rd_phase + 3'h1;
    nxt_st.rclk = !st_ff.rclk;
    if (rd_evt && rd_clk_win) begin
      nxt_st.rd_phase = mwpc_pkg::CLK_LOCK;
      nxt_st.rclk = 1'b1;
    end
    if (rd_evt && !rd_clk_win) begin
      nxt_st.rd_seen = 1'b1;
    end
    nxt_st.rd_stb = 1'b0;
    if (st_ff.rd_phase == mwpc_pkg::CELL_LAST) begin
      nxt_st.rd_bit = st_ff.rd_seen || (rd_evt && !rd_clk_win);
      nxt_st.rd_stb = 1'b1;
      nxt_st.rd_seen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st_ff <= mwpc_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign WCLK_O = st_ff.wclk;
  assign CPU_CLK_O = st_ff.wclk;
  assign PRECOMP_ENABLE_LINE_O = st_ff.ctrl[mwpc_pkg::CTRL_PC_EN_BIT];
  assign SHIFT_EARLY_O = (st_ff.outcome == mwpc_pkg::MWPC_SHIFT_EARLY);
  assign SHIFT_LATE_O = (st_ff.outcome == mwpc_pkg::MWPC_SHIFT_LATE);
  assign SHIFT_NONE_O = !SHIFT_EARLY_O && !SHIFT_LATE_O;
  assign ENCODED_WRITE_OUT_O = st_ff.enc;
  assign ENC_WR_P_O = st_ff.enc;
  assign ENC_WR_N_O = !st_ff.enc;
  assign RDATA_O = st_ff.rdata;
  assign RCLK_O = st_ff.rclk;
  assign RD_BIT_O = st_ff.rd_bit;
  assign RD_BIT_STB_O = st_ff.rd_stb;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_wclk_half;
    @(posedge REF_CLK_I) disable iff (RST_I)
    WCLK_O |=> !WCLK_O ##1 WCLK_O;
  endproperty
  a_wclk_half: assert property (p_wclk_half) else $error("Write clock not halved");

  property p_cpu_clk;
    @(posedge REF_CLK_I) disable iff (RST_I)
    CPU_CLK_O == WCLK_O;
  endproperty
  a_cpu_clk: assert property (p_cpu_clk) else $error("Processor clock differs");

  property p_one_outcome;
    @(posedge REF_CLK_I) disable iff (RST_I)
    $onehot({SHIFT_EARLY_O, SHIFT_NONE_O, SHIFT_LATE_O});
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("Outcome not one-hot");

  property p_early_data;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (st_ff.wr == mwpc_pkg::MWPC_WR_SHIFT) && cur && (shift_c == mwpc_pkg::MWPC_SHIFT_EARLY)
      && (st_ff.phase == mwpc_pkg::DAT_POS - mwpc_pkg::PC_DELAY) |=> ENC_WR_P_O ##1 !ENC_WR_P_O;
  endproperty
  a_early_data: assert property (p_early_data) else $error("Early pulse misplaced");

  property p_no_shift_off;
    @(posedge REF_CLK_I) disable iff (RST_I)
    !PRECOMP_ENABLE_LINE_O |=> SHIFT_NONE_O;
  endproperty
  a_no_shift_off: assert property (p_no_shift_off) else $error("Shift while disabled");

  property p_diff_pair;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (ENC_WR_N_O != ENC_WR_P_O) && (ENC_WR_P_O == ENCODED_WRITE_OUT_O);
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("Differential pair broken");

  property p_clock_pulse;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (st_ff.wr == mwpc_pkg::MWPC_WR_SHIFT) && !cur && !st_ff.prev
      && (st_ff.phase == mwpc_pkg::CLK_POS) && (shift_c == mwpc_pkg::MWPC_SHIFT_NONE)
      |=> ENCODED_WRITE_OUT_O;
  endproperty
  a_clock_pulse: assert property (p_clock_pulse) else $error("Missing clock pulse");

  property p_zero_quiet;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (st_ff.wr == mwpc_pkg::MWPC_WR_SHIFT) && !cur && st_ff.prev |=> !ENCODED_WRITE_OUT_O;
  endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("Pulse in empty cell");

  property p_resync;
    @(posedge REF_CLK_I) disable iff (RST_I)
    rd_evt && rd_clk_win |=> (st_ff.rd_phase == mwpc_pkg::CLK_LOCK) && RCLK_O;
  endproperty
  a_resync: assert property (p_resync) else $error("No resync on clock pulse");

  property p_rclk_free;
    @(posedge REF_CLK_I) disable iff (RST_I)
    !(rd_evt && rd_clk_win) |=> (RCLK_O != $past(RCLK_O));
  endproperty
  a_rclk_free: assert property (p_rclk_free) else $error("Read clock stalled");

endmodule : mwpc_top

/* File: mwpc_drive_model.sv */
/*
  Disk drive model for the MFM write precompensation and clocking block.
  Watches the differential write pair and plays MFM read pulses on request.
  Assumes the block's 8-cycle bit cell and the shared reference clock.
*/
module mwpc_drive_model (
  input wire logic clk_i, // Reference clock
  input wire logic p_i, // Write pair true side
  input wire logic n_i, // Write pair complement side
  input wire logic play_i, // Start playback, one cycle
  input wire logic [23:0] pat_i, // Bits to play, MSB first
  output logic rd_o, // Read pulses to the block
  output logic busy_o, // Playback running
  output int pair_err_o // Cycles with a broken pair
);
  timeunit 1ns;
  timeprecision 1ns;

  // ====================
  // Playback
  // ====================
  logic [23:0] sr; // Bits still to play
  logic [7:0] cnt; // Cycle within playback
  logic prev; // Last played data bit

  initial begin
    rd_o = 1'b0;
    busy_o = 1'b0;
    pair_err_o = 0;
    prev = 1'b0;
  end

  // Pulses last two cycles so the block's pin filter can accept them
  always @(posedge clk_i) begin
    rd_o <= 1'b0;
    if (play_i) begin
      busy_o <= 1'b1;
      sr <= pat_i;
      cnt <= 8'h00;
      prev <= 1'b0;
    end else if (busy_o) begin
      if (cnt[2:1] == 2'h3 && sr[23]) rd_o <= 1'b1;
      if (cnt[2:1] == 2'h1 && !sr[23] && !prev) rd_o <= 1'b1;
      if (cnt[2:0] == 3'h7) begin
        prev <= sr[23];
        sr <= {sr[22:0], 1'b0};
      end
      busy_o <= (cnt != 8'hbf);
      cnt <= cnt + 8'h01;
    end
    // A pair whose sides agree would read as no transition at the drive;
    // unknown sides before the first reset edge compare unknown and are not counted
    if (p_i == n_i) pair_err_o <= pair_err_o + 1;
  end
endmodule : mwpc_drive_model

/* File: mfm_write_precomp_and_clocking_tb_top.sv */
/*
  Self-checking bench for the MFM write precompensation and clocking block.
  Assumes the register port, byte stream and read pin described by the design.
*/
module mfm_write_precomp_and_clocking_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ====================
  // Signals
  // ====================
  logic clk, rst, wr, rd, wr_valid, play, busy, rec, live, wclk_q, rclk_q, found;
  logic [3:0] addr;
  logic [31:0] wdata, hist, row;
  logic [7:0] wr_byte;
  logic [23:0] pat;
  int failures, n_checks, np, ne, nl, t0, t1, cyc, nstb, rsame, pair_err, i;
  // Rows: en, byte, pulses, early, late, first gap in cycles
  logic [31:0] rows [7] = '{32'h0008_0008, 32'h1008_0008, 32'h1ff8_170a, 32'h0ff8_0008,
                            32'h1a55_4010, 32'h1817_200d, 32'h1c37_220a};
  logic [31:0] rdata;
  logic wr_ready, wclk, cpu_clk, pc_en, s_e, s_n, s_l, enc, enc_p, enc_n, rd_mfm, rclk;
  logic rbit, rstb;

  mwpc_top DUT (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .WR_DATA_I(wr_byte), .WR_VALID_I(wr_valid),
    .WR_READY_O(wr_ready), .WCLK_O(wclk), .CPU_CLK_O(cpu_clk),
    .PRECOMP_ENABLE_LINE_O(pc_en), .SHIFT_EARLY_O(s_e), .SHIFT_NONE_O(s_n),
    .SHIFT_LATE_O(s_l), .ENCODED_WRITE_OUT_O(enc), .ENC_WR_P_O(enc_p), .ENC_WR_N_O(enc_n),
    .RD_MFM_I(rd_mfm), .RCLK_O(rclk), .RD_BIT_O(rbit), .RD_BIT_STB_O(rstb));

  mwpc_drive_model drive (.clk_i(clk), .p_i(enc_p), .n_i(enc_n), .play_i(play),
    .pat_i(pat), .rd_o(rd_mfm), .busy_o(busy), .pair_err_o(pair_err));

  // ====================
  // Tasks
  // ====================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Strobes last one cycle; a spare cycle follows so no signal is set twice at one edge
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(nm, rdata, e);
    @(posedge clk);
  endtask : reg_rd

  // Holds the byte offered for n cycles back to back
  task automatic push_n(input int n, input logic [7:0] b);
    wr_byte <= b;
    wr_valid <= 1'b1;
    repeat (n) @(posedge clk);
    wr_valid <= 1'b0;
    @(posedge clk);
  endtask : push_n

  task automatic pulse_reset();
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : pulse_reset

  // ====================
  // Monitor
  // ====================
  // Samples at the edge, so it sees the values the design launched last cycle
  always @(posedge clk) begin
    cyc++;
    if (rst) live <= 1'b0;
    else begin
      if (live) check("wclk_toggle", {31'h0, wclk ^ wclk_q}, 32'h1);
      live <= 1'b1;
      wclk_q <= wclk;
      check("cpu_clk", {31'h0, cpu_clk}, {31'h0, wclk});
      check("outcome_onehot", 32'($countones({s_e, s_n, s_l})), 32'h1);
      if (rec && enc) begin
        if (np == 0) t0 = cyc;
        else if (np == 1) t1 = cyc;
        np++;
        ne += s_e;
        nl += s_l;
      end
      if (rstb) begin
        hist = {hist[30:0], rbit};
        nstb++;
      end
      rsame += (rclk == rclk_q);
      rclk_q = rclk;
    end
  end

  // ====================
  // Clock, watchdog
  // ====================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Longest path is the 2048-cycle drain; this leaves ample margin
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    finish_test();
  end

  // ====================
  // Main sequence
  // ====================
  initial begin
    {rst, wr, rd, wr_valid, play, rec} = 6'h21;
    {addr, wdata, wr_byte, pat, hist} = '0;
    {failures, n_checks, cyc} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("reset_outs", {27'h0, s_n, wr_ready, enc_n, enc_p, pc_en}, 32'h1c);
    @(posedge clk);
    reg_rd(mwpc_pkg::REG_CTRL, 32'h0, "ctrl_reset");
    reg_rd(mwpc_pkg::REG_STATUS, 32'h2, "status_reset");
    reg_wr(4'h8, 32'hffff_ffff);
    reg_rd(4'h8, 32'h0, "unmapped");
    reg_rd(mwpc_pkg::REG_CTRL, 32'h0, "ctrl_unmapped_write");
    reg_wr(mwpc_pkg::REG_CTRL, 32'hffff_fffd);
    reg_rd(mwpc_pkg::REG_CTRL, 32'h1, "ctrl_upper_bits");
    check("enable_line", {31'h0, pc_en}, 32'h1);
    // Rows: one byte each, from a fresh reset so the previous bit starts at zero
    foreach (rows[k]) begin
      row = rows[k];
      pulse_reset();
      {np, ne, nl} = '0;
      rec = 1'b1;
      reg_wr(mwpc_pkg::REG_CTRL, {30'h0, 1'b1, row[28]});
      push_n(1, row[27:20]);
      repeat (4) @(posedge clk);
      reg_wr(mwpc_pkg::REG_CTRL, {31'h0, row[28]});
      repeat (100) @(posedge clk);
      rec = 1'b0;
      check("pulses", 32'(np), {28'h0, row[19:16]});
      check("early", 32'(ne), {28'h0, row[15:12]});
      check("late", 32'(nl), {28'h0, row[11:8]});
      check("first_gap", 32'(t1 - t0), {24'h0, row[7:0]});
    end
    // Fill past full; the 33rd offer must be refused
    pulse_reset();
    {np, ne, nl} = '0;
    rec = 1'b1;
    push_n(33, 8'h00);
    #1 check("ready_full", {31'h0, wr_ready}, 32'h0);
    @(posedge clk);
    reg_rd(mwpc_pkg::REG_STATUS, 32'h2004, "status_full");
    reg_wr(mwpc_pkg::REG_CTRL, 32'h2);
    repeat (2200) @(posedge clk);
    rec = 1'b0;
    check("drain_pulses", 32'(np), 32'd256);
    reg_rd(mwpc_pkg::REG_STATUS, 32'h2, "status_empty");
    check("pair", 32'(pair_err), 32'h0);
    // Read: clock-pulse preamble for lock, then a data byte
    pulse_reset();
    pat <= 24'h00005a;
    play <= 1'b1;
    @(posedge clk);
    play <= 1'b0;
    repeat (2) @(posedge clk);
    for (i = 0; i < 300 && busy; i++) @(posedge clk);
    repeat (16) @(posedge clk);
    found = 1'b0;
    for (i = 0; i < 17; i++) if (hist[i +: 16] == 16'h005a) found = 1'b1;
    check("read_bits", {31'h0, found}, 32'h1);
    // With no pulses the cell timing must run on by itself
    // Off the edge, so the monitor counts exactly 80 edges in the window
    #1 {nstb, rsame} = '0;
    repeat (80) @(posedge clk);
    #1 check("idle_strobes", 32'(nstb), 32'd10);
    check("rclk_half_rate", 32'(rsame), 32'h0);
    finish_test();
  end
endmodule : mfm_write_precomp_and_clocking_tb_top
